// *** dmaevm_params.svh ***
// Register offsets, field layouts, reset values and channel numbers of the event map
`ifndef DMAEVM_PARAMS_SVH
`define DMAEVM_PARAMS_SVH

`define DMAEVM_NUM_CH         64
`define DMAEVM_OFF_LATCH_LO   4'h0
`define DMAEVM_OFF_LATCH_HI   4'h1
`define DMAEVM_OFF_ENABLE_LO  4'h2
`define DMAEVM_OFF_ENABLE_HI  4'h3
`define DMAEVM_OFF_SET_LO     4'h4
`define DMAEVM_OFF_SET_HI     4'h5
`define DMAEVM_OFF_CLR_LO     4'h6
`define DMAEVM_OFF_CLR_HI     4'h7
`define DMAEVM_OFF_IRQ_STAT   4'h8
`define DMAEVM_OFF_IRQ_MASK   4'h9
`define DMAEVM_OFF_VARIANT    4'ha
`define DMAEVM_ENABLE_RST     32'h0000_0000
`define DMAEVM_MASK_RST       4'h0
`define DMAEVM_IRQ_MISSED_LO  0
`define DMAEVM_IRQ_MISSED_HI  1
`define DMAEVM_IRQ_SUBMIT     2
`define DMAEVM_IRQ_CHAIN      3
`define DMAEVM_IRQ_W          4
`define DMAEVM_VAR_HOSTBUS    0
`define DMAEVM_VAR_DECODERS   1
`define DMAEVM_VAR_CELL       2
`define DMAEVM_CH_HOST        0
`define DMAEVM_CH_TIMER0      1
`define DMAEVM_CH_TIMER1      2
`define DMAEVM_CH_MEMA        3
`define DMAEVM_CH_PIN4        4
`define DMAEVM_CH_PIN0        8
`define DMAEVM_CH_SER0_TX     12
`define DMAEVM_CH_SER1_TX     14
`define DMAEVM_CH_SER2_TX     17
`define DMAEVM_CH_TIMER2      19
`define DMAEVM_CH_MEMB        20
`define DMAEVM_CH_VIT_RX      28
`define DMAEVM_CH_TURBO_RX    30
`define DMAEVM_CH_CELL_RX     32
`define DMAEVM_CH_CELL_TX     40
`define DMAEVM_CH_PIN8        48

`endif

// *** dmaevm_pkg.sv ***
// Types shared by the event map
`default_nettype none
package dmaevm_pkg;
  // Hardware event sources, each one-cycle or level from on-chip logic
  typedef struct packed {
    logic        host_event;
    logic        host_from_hostbus;
    logic [2:0]  timer_event;
    logic        mem_if_a_refresh_event;
    logic        mem_if_b_refresh_event;
    logic [15:0] pin_event;
    logic        serial0_tx_event;
    logic        serial0_rx_event;
    logic        serial1_tx_event;
    logic        serial1_rx_event;
    logic        serial2_tx_event;
    logic        serial2_rx_event;
    logic        viterbi_rx_event;
    logic        viterbi_tx_event;
    logic        turbo_rx_event;
    logic        turbo_tx_event;
    logic        cell_rx_event;
    logic        cell_tx_event;
  } dmaevm_src_t;

  // Request handed to the transfer engine
  typedef struct packed {
    logic       valid;
    logic [5:0] channel;
  } dmaevm_req_t;
endpackage : dmaevm_pkg
`default_nettype wire

// *** dmaevm_properties.sv ***
// Port-level assertions for the event map
`default_nettype none
module dmaevm_properties (
  input wire logic                    i_clk,
  input wire logic                    i_rstn,
  input wire logic                    i_wb_cyc,
  input wire logic                    i_wb_stb,
  input wire logic                    i_wb_we,
  input wire logic [5:0]              i_wb_adr,
  input wire logic [2:0]              i_variant_strap,
  input wire logic                    i_svc_ready,
  input wire logic [2:0]              i_svc_prio,
  input wire logic [31:0]             o_wb_dat,
  input wire logic                    o_wb_ack,
  input wire logic                    o_irq,
  input wire dmaevm_pkg::dmaevm_req_t o_req,
  input wire logic [2:0]              o_req_prio
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  a_req_one_cycle: assert property (o_req.valid |=> !o_req.valid)
    else $error("request too long");
  a_req_when_ready: assert property (o_req.valid |-> $past(i_svc_ready))
    else $error("request while not ready");
  a_req_prio_taken: assert property (o_req.valid |-> o_req_prio == $past(i_svc_prio))
    else $error("request priority wrong");
  a_unmapped_zero: assert property
    (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) >= 6'h2c |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  a_variant_read: assert property
    (o_wb_ack && !$past(i_wb_we) && $past(i_wb_adr) == 6'h28 |->
     o_wb_dat == {29'h0, i_variant_strap})
    else $error("variant read wrong");
  a_irq_fall_write: assert property ($fell(o_irq) |-> o_wb_ack || $past(o_wb_ack))
    else $error("irq fell without a write");
endmodule : dmaevm_properties
bind dmaevm_top dmaevm_properties dmaevm_properties_i (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_variant_strap, .i_svc_ready, .i_svc_prio, .o_wb_dat, .o_wb_ack,
  .o_irq, .o_req, .o_req_prio);
`default_nettype wire

// *** dmaevm_src_model.sv ***
// Peripheral event source model: pulses one source line for one cycle
`default_nettype none
module dmaevm_src_model (
  input  wire logic               i_clk,
  input  wire logic               i_fire,
  input  wire logic [5:0]         i_bit,
  output var dmaevm_pkg::dmaevm_src_t o_src
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_clk) begin
    o_src <= '0;
    if (i_fire) begin
      o_src[i_bit] <= 1'b1;
    end
  end
endmodule : dmaevm_src_model
`default_nettype wire

// *** dmaevm_top.sv ***
// Event capture and fixed channel mapping front end of the DMA controller
// What this block does
// - Sixty-four channels, numbered 0 to 63
// - Event to channel mapping fixed in wiring
// - Events latch even while channel disabled
// - Priority comes from i_svc_prio, taken in the cycle the channel is picked
// - Channel 0 takes the host port event
// - Channels 3, 20 take memory refresh events
// - Pin events map to 4-11 and 48-55
// - Serial ports map to 12-15, 17-18
// - Decoder events map to channels 28-31
// - Cell interface events to channels 32, 40
// - Channels 1, 2, 19 take timer events; unlisted ones have no hardware source
// - Every channel also takes completion chaining
`include "dmaevm_params.svh"
`default_nettype none
module dmaevm_top #(
  parameter int NUM_CH = `DMAEVM_NUM_CH
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rstn,
  input  wire dmaevm_pkg::dmaevm_src_t   i_src,
  input  wire logic [NUM_CH-1:0]         i_chain_event,
  input  wire logic [NUM_CH-1:0]         i_chain_alt_event,
  input  wire logic [2:0]                i_variant_strap,
  input  wire logic                      i_svc_ready,
  input  wire logic [2:0]                i_svc_prio,
  input  wire logic                      i_svc_done,
  input  wire logic [5:0]                i_svc_done_ch,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [5:0]                i_wb_adr,
  input  wire logic [31:0]               i_wb_dat,
  input  wire logic [3:0]                i_wb_sel,
  output logic [31:0]                    o_wb_dat,
  output logic                           o_wb_ack,
  output logic                           o_irq,
  output dmaevm_pkg::dmaevm_req_t        o_req,
  output logic [2:0]                     o_req_prio
);

  // Variant straps: bit set means the optional unit is present
  logic [2:0]        variant;
  logic              strap_taken;
  logic [NUM_CH-1:0] latch;
  logic [NUM_CH-1:0] enable;
  logic [`DMAEVM_IRQ_W-1:0] irq_stat;
  logic [`DMAEVM_IRQ_W-1:0] irq_mask;
  logic [NUM_CH-1:0] hw_event;
  logic [NUM_CH-1:0] all_event;
  logic [NUM_CH-1:0] pending;
  logic              has_pending;
  logic [5:0]        pick;
  logic              pick_fire;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      variant     <= 3'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      variant     <= i_variant_strap;
      strap_taken <= 1'b1;
    end
  end

  // Pin events arrive from outside the clock's domain: two flops before any use.
  // The cost is two cycles of extra latency on channels 4-11 and 48-55 only.
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= i_src.pin_event;
      pin_sync <= pin_meta;
    end
  end

  wire host_ok  = variant[`DMAEVM_VAR_HOSTBUS];
  wire dec_ok   = variant[`DMAEVM_VAR_DECODERS];
  wire cell_ok  = variant[`DMAEVM_VAR_CELL];

  // Fixed wiring of every hardware source to its one channel
  always_comb begin
    hw_event = '0;
    hw_event[`DMAEVM_CH_HOST] = i_src.host_event &
                                (host_ok | ~i_src.host_from_hostbus);
    hw_event[`DMAEVM_CH_TIMER0] = i_src.timer_event[0];
    hw_event[`DMAEVM_CH_TIMER1] = i_src.timer_event[1];
    hw_event[`DMAEVM_CH_TIMER2] = i_src.timer_event[2];
    hw_event[`DMAEVM_CH_MEMA]   = i_src.mem_if_a_refresh_event;
    hw_event[`DMAEVM_CH_MEMB]   = i_src.mem_if_b_refresh_event;
    hw_event[`DMAEVM_CH_PIN4 +: 4] = pin_sync[7:4];
    hw_event[`DMAEVM_CH_PIN0 +: 4] = pin_sync[3:0];
    hw_event[`DMAEVM_CH_PIN8 +: 8] = pin_sync[15:8];
    hw_event[`DMAEVM_CH_SER0_TX]     = i_src.serial0_tx_event;
    hw_event[`DMAEVM_CH_SER0_TX + 1] = i_src.serial0_rx_event;
    hw_event[`DMAEVM_CH_SER1_TX]     = i_src.serial1_tx_event;
    hw_event[`DMAEVM_CH_SER1_TX + 1] = i_src.serial1_rx_event;
    hw_event[`DMAEVM_CH_SER2_TX]     = i_src.serial2_tx_event;
    hw_event[`DMAEVM_CH_SER2_TX + 1] = i_src.serial2_rx_event;
    hw_event[`DMAEVM_CH_VIT_RX]       = i_src.viterbi_rx_event & dec_ok;
    hw_event[`DMAEVM_CH_VIT_RX + 1]   = i_src.viterbi_tx_event & dec_ok;
    hw_event[`DMAEVM_CH_TURBO_RX]     = i_src.turbo_rx_event & dec_ok;
    hw_event[`DMAEVM_CH_TURBO_RX + 1] = i_src.turbo_tx_event & dec_ok;
    hw_event[`DMAEVM_CH_CELL_RX] = i_src.cell_rx_event & cell_ok;
    hw_event[`DMAEVM_CH_CELL_TX] = i_src.cell_tx_event & cell_ok;
  end

  assign all_event = hw_event | i_chain_event | i_chain_alt_event;

  // Bus decode
  wire        wb_hit   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire        wb_wr    = wb_hit & i_wb_we & (&i_wb_sel);
  wire [3:0]  wb_idx   = i_wb_adr[5:2];
  wire        wr_en_lo = wb_wr & (wb_idx == `DMAEVM_OFF_ENABLE_LO);
  wire        wr_en_hi = wb_wr & (wb_idx == `DMAEVM_OFF_ENABLE_HI);
  wire        wr_set_lo = wb_wr & (wb_idx == `DMAEVM_OFF_SET_LO);
  wire        wr_set_hi = wb_wr & (wb_idx == `DMAEVM_OFF_SET_HI);
  wire        wr_clr_lo = wb_wr & (wb_idx == `DMAEVM_OFF_CLR_LO);
  wire        wr_clr_hi = wb_wr & (wb_idx == `DMAEVM_OFF_CLR_HI);
  wire        wr_stat  = wb_wr & (wb_idx == `DMAEVM_OFF_IRQ_STAT);
  wire        wr_mask  = wb_wr & (wb_idx == `DMAEVM_OFF_IRQ_MASK);

  wire [NUM_CH-1:0] sw_set = {wr_set_hi ? i_wb_dat : 32'h0000_0000,
                              wr_set_lo ? i_wb_dat : 32'h0000_0000};
  wire [NUM_CH-1:0] sw_clr = {wr_clr_hi ? i_wb_dat : 32'h0000_0000,
                              wr_clr_lo ? i_wb_dat : 32'h0000_0000};

  // Service arbitration: lowest enabled pending channel is submitted
  assign pending     = latch & enable;
  assign has_pending = |pending;

  function automatic logic [5:0] lowest_set(input logic [NUM_CH-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 6'(k);
      end
    end
    return r;
  endfunction : lowest_set

  assign pick      = lowest_set(pending);
  assign pick_fire = has_pending & i_svc_ready & ~o_req.valid;

  wire [NUM_CH-1:0] svc_clr = i_svc_done ? (NUM_CH'(1) << i_svc_done_ch) : '0;

  // New events win over any clear in the same cycle
  wire [NUM_CH-1:0] next_latch = (latch & ~(sw_clr | svc_clr)) | sw_set
                                 | all_event;

  // Event lost because its bit was already set
  wire miss_lo  = |(all_event[31:0] & latch[31:0]);
  wire miss_hi  = |(all_event[63:32] & latch[63:32]);
  wire chain_in = |(i_chain_event | i_chain_alt_event);
  wire [`DMAEVM_IRQ_W-1:0] irq_evt = {chain_in, pick_fire, miss_hi, miss_lo};
  wire [`DMAEVM_IRQ_W-1:0] wr_stat_bits = wr_stat ? i_wb_dat[`DMAEVM_IRQ_W-1:0] : '0;
  wire [`DMAEVM_IRQ_W-1:0] next_irq_stat = (irq_stat & ~wr_stat_bits) | irq_evt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch <= '0;
    end else begin
      latch <= next_latch;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      enable   <= {`DMAEVM_ENABLE_RST, `DMAEVM_ENABLE_RST};
      irq_mask <= `DMAEVM_MASK_RST;
      irq_stat <= '0;
    end else begin
      if (wr_en_lo) enable[31:0]  <= i_wb_dat;
      if (wr_en_hi) enable[63:32] <= i_wb_dat;
      if (wr_mask) irq_mask <= i_wb_dat[`DMAEVM_IRQ_W-1:0];
      irq_stat <= next_irq_stat;
    end
  end

  // Request goes out with the priority sampled from i_svc_prio in the cycle it is picked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_req      <= '0;
      o_req_prio <= 3'h0;
    end else begin
      o_req.valid <= pick_fire;
      if (pick_fire) begin
        o_req.channel <= pick;
        o_req_prio    <= i_svc_prio;
      end
    end
  end

  // Read mux
  logic [31:0] rd_data;
  always_comb begin
    case (wb_idx)
      `DMAEVM_OFF_LATCH_LO:  rd_data = latch[31:0];
      `DMAEVM_OFF_LATCH_HI:  rd_data = latch[63:32];
      `DMAEVM_OFF_ENABLE_LO: rd_data = enable[31:0];
      `DMAEVM_OFF_ENABLE_HI: rd_data = enable[63:32];
      `DMAEVM_OFF_IRQ_STAT:  rd_data = {28'h000_0000, irq_stat};
      `DMAEVM_OFF_IRQ_MASK:  rd_data = {28'h000_0000, irq_mask};
      `DMAEVM_OFF_VARIANT:   rd_data = {29'h0000_0000, variant};
      default:               rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      o_irq    <= 1'b0;
    end else begin
      o_wb_ack <= wb_hit;
      o_wb_dat <= (wb_hit & ~i_wb_we) ? rd_data : 32'h0000_0000;
      o_irq    <= |(next_irq_stat & irq_mask);
    end
  end

endmodule : dmaevm_top
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the event map
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk, rstn, fire, cyc, stb, we, rdy, done, ack, irq;
  logic [5:0]              bitn, adr, dch, rch;
  logic [2:0]              prio, rpo, rpr, strap;
  logic [31:0]             wd, rd, rdq;
  logic [63:0]             cev, aev;
  dmaevm_pkg::dmaevm_src_t src;
  dmaevm_pkg::dmaevm_req_t req;
  int                      num_errors, comparisons, nreq;
  dmaevm_src_model dmaevm_src_model_i (.i_clk(clk), .i_fire(fire), .i_bit(bitn), .o_src(src));
  dmaevm_top dmaevm_top_i (.i_clk(clk), .i_rstn(rstn), .i_src(src), .i_chain_event(cev),
    .i_chain_alt_event(aev), .i_variant_strap(strap), .i_svc_ready(rdy), .i_svc_prio(prio),
    .i_svc_done(done), .i_svc_done_ch(dch), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hf), .o_wb_dat(rd), .o_wb_ack(ack),
    .o_irq(irq), .o_req(req), .o_req_prio(rpo));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (req.valid === 1'b1) begin
    nreq++;
    rch = req.channel;
    rpr = rpo;
  end
  task automatic conclude;
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    rdq = rd;
    cyc <= 0; stb <= 0;
    if (n == 20) num_errors++;
    @(posedge clk);
  endtask : wb
  task automatic rdlatch(output logic [63:0] v);
    wb(0, 6'h04, 0);
    v[63:32] = rdq;
    wb(0, 6'h00, 0);
    v[31:0] = rdq;
  endtask : rdlatch
  // Channel fed by each source bit, source bits counted from the struct's low end
  function automatic int ch_of(input int b);
    int t[12] = '{40, 32, 31, 30, 29, 28, 18, 17, 15, 14, 13, 12};
    int u[7] = '{20, 3, 1, 2, 19, 0, 0};
    if (b < 12) return t[b];
    if (b < 16) return b - 4;
    if (b < 20) return b - 12;
    if (b < 28) return b + 28;
    return u[b - 28];
  endfunction : ch_of
  task automatic t_regs;
    logic [5:0]  a[5] = '{6'h08, 6'h0c, 6'h24, 6'h28, 6'h3c};
    logic [31:0] e[5] = '{0, 0, 0, 7, 0};
    foreach (a[i]) begin
      wb(0, a[i], 0);
      chk("register", e[i], rdq);
    end
  endtask : t_regs
  // Every source alone, channels left disabled
  task automatic t_map;
    logic [63:0] v;
    for (int b = 0; b < 35; b++) if (b != 33) begin
      fire <= 1; bitn <= 6'(b);
      @(posedge clk);
      fire <= 0;
      repeat (3) @(posedge clk);
      rdlatch(v);
      chk("latch", 64'h1 << ch_of(b), v);
      wb(1, 6'h18, 32'hffffffff);
      wb(1, 6'h1c, 32'hffffffff);
    end
    chk("requests", 0, nreq);
  endtask : t_map
  task automatic t_submit;
    logic [63:0] v;
    wb(1, 6'h24, 32'h4);
    cev <= 64'h8; aev <= 64'h1 << 63; fire <= 1; bitn <= 6'd17;
    @(posedge clk);
    cev <= 0; aev <= 0; fire <= 0;
    repeat (8) @(posedge clk);
    rdlatch(v);
    chk("latch", 64'h8000_0000_0000_0028, v);
    wb(1, 6'h08, 32'h28);
    repeat (3) @(posedge clk);
    chk("req_channel", 3, rch);
    chk("req_prio", 5, rpr);
    chk("irq", 1, irq);
    for (int k = 3; k < 6; k += 2) begin
      done <= 1; dch <= 6'(k);
      @(posedge clk);
      done <= 0;
      repeat (4) @(posedge clk);
    end
    chk("req_channel", 5, rch);
    wb(1, 6'h20, 32'hf);
    repeat (3) @(posedge clk);
    chk("irq", 0, irq);
    rdlatch(v);
    chk("latch", 64'h8000_0000_0000_0000, v);
  endtask : t_submit
  // Mid-run reset into the bare variant: decoder and cell events drop, host port event still latches
  task automatic t_variant;
    logic [63:0] v;
    int          s[7] = '{5, 4, 3, 2, 1, 0, 34};
    rstn <= 0; strap <= 3'h0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    wb(0, 6'h28, 0);
    chk("variant", 0, rdq);
    foreach (s[i]) begin
      fire <= 1; bitn <= 6'(s[i]);
      @(posedge clk);
    end
    fire <= 0;
    repeat (3) @(posedge clk);
    rdlatch(v);
    chk("latch", 64'h1, v);
  endtask : t_variant
  initial begin
    rstn = 0; fire = 0; bitn = 0; cyc = 0; stb = 0; we = 0; adr = 0; wd = 0;
    cev = 0; aev = 0; rdy = 1; prio = 3'h5; done = 0; dch = 0; strap = 3'h7;
    num_errors = 0; comparisons = 0; nreq = 0;
    repeat (16) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    t_regs;
    t_map;
    t_submit;
    t_variant;
    conclude;
  end
  initial begin
    #100us;
    num_errors++;
    conclude;
  end
endmodule : tb
`default_nettype wire
